/* src/dcc_pkg.sv */
// Package of offsets, field positions, reset values and types for the debug capture control
package dcc_pkg;

   // Register byte offsets on APB
   localparam logic [7:0] OFS_FIFO_HIGH = 8'h00;
   localparam logic [7:0] OFS_FIFO_LOW  = 8'h04;
   localparam logic [7:0] OFS_FIFO_EXT  = 8'h08;
   localparam logic [7:0] OFS_CTRL      = 8'h0C;
   localparam logic [7:0] OFS_TRIG      = 8'h10;
   localparam logic [7:0] OFS_COMPC     = 8'h14;
   localparam logic [7:0] OFS_COUNT     = 8'h18;

   // Control register fields
   localparam int         CTL_EN      = 7;
   localparam int         CTL_ARM     = 6;
   localparam int         CTL_TAG     = 5;
   localparam int         CTL_BRK     = 4;
   localparam int         CTL_LOOP    = 0;
   localparam logic [7:0] CTL_WMASK   = 8'hF1;
   localparam logic [7:0] CTL_RST     = 8'h00;
   localparam logic [7:0] CTL_KEEPCLR = 8'h50;

   // Extended information fields
   localparam int         FX_PAGED = 7;
   localparam int         FX_MSB   = 0;

   // Trigger register fields and modes
   localparam int         TRG_BEGIN    = 6;
   localparam logic [7:0] TRG_WMASK    = 8'hCF;
   localparam logic [7:0] TRG_RST      = 8'h00;
   localparam logic [3:0] MODE_EVT_B   = 4'h3;
   localparam logic [3:0] MODE_A_EVT_B = 4'h4;

   // Captured word: paged flag above a 17-bit address
   localparam int         ADDR_W     = 17;
   localparam int         WORD_W     = 18;
   localparam int         FIFO_DEPTH = 8;
   localparam logic [17:0] COMPC_RST = 18'h0_0000;

   // Reset causes, presented with RESET
   localparam logic [1:0] RK_POR       = 2'h0;
   localparam logic [1:0] RK_OTHER     = 2'h1;
   localparam logic [1:0] RK_END_RUN   = 2'h2;
   localparam logic [1:0] RK_END_TRACE = 2'h3;

   typedef enum logic [1:0] {
      TR_IDLE,
      TR_WAIT,
      TR_STORE
   } dcc_trace_e;

endpackage

/* src/dcc_apb_slave.sv */
// APB slave front end: zero-wait answer, registered read data, error on unmapped
`timescale 1ns/1ps
`default_nettype none
module dcc_apb_slave (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] reg_rdata,
   input  wire logic        reg_hit,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             wr_stb,
   output logic             rd_stb
);

   logic [31:0] prdata_q;
   logic        hit_q;
   logic        access;

   // Read data is latched in the setup cycle so it comes from a flop in the access phase
   always_ff @(posedge clk) begin
      if (rst) begin
         prdata_q <= 32'h0000_0000;
         hit_q    <= 1'b0;
      end else if (psel && !penable) begin
         prdata_q <= pwrite ? 32'h0000_0000 : reg_rdata;
         hit_q    <= reg_hit;
      end
   end

   assign access  = psel && penable;
   assign prdata  = prdata_q;
   assign pready  = 1'b1;
   assign pslverr = access && !hit_q;
   assign wr_stb  = access && pwrite && hit_q;
   assign rd_stb  = access && !pwrite && hit_q;

endmodule // dcc_apb_slave
`default_nettype wire

/* src/dcc_capture_fifo.sv */
// Capture FIFO in flip-flops, with optional overwrite of the oldest word when full
`timescale 1ns/1ps
`default_nettype none
module dcc_capture_fifo #(
   parameter int W     = 18,
   parameter int DEPTH = 8,
   parameter int CW    = $clog2(DEPTH + 1)
) (
   input  wire logic          clk,
   input  wire logic          rst,
   input  wire logic          push,
   input  wire logic          pop,
   input  wire logic          overwrite,
   input  wire logic [W-1:0]  wdata,
   output logic      [W-1:0]  head,
   output logic               full,
   output logic               empty,
   output logic      [CW-1:0] count
);

   localparam int PW = $clog2(DEPTH);

   logic [W-1:0]  mem_q [DEPTH];
   logic [PW-1:0] wp_q;
   logic [PW-1:0] rp_q;
   logic [CW-1:0] cnt_q;
   logic          do_push;
   logic          drop;
   logic          do_pop;

   function automatic logic [PW-1:0] step(input logic [PW-1:0] p);
      step = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
   endfunction

   assign full    = (cnt_q == CW'(DEPTH));
   assign empty   = (cnt_q == '0);
   assign do_push = push && (!full || overwrite);
   assign drop    = push && full && overwrite;
   assign do_pop  = pop && !empty && !drop;

   always_ff @(posedge clk) begin
      if (do_push) begin
         mem_q[wp_q] <= wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wp_q  <= '0;
         rp_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (do_push) begin
            wp_q <= step(wp_q);
         end
         if (do_pop || drop) begin
            rp_q <= step(rp_q);
         end
         if (do_push && !drop && !do_pop) begin
            cnt_q <= cnt_q + CW'(1);
         end else if (do_pop && !do_push) begin
            cnt_q <= cnt_q - CW'(1);
         end
      end
   end

   // An empty FIFO reads as zero so a cleared FIFO shows cleared bytes
   assign head  = empty ? '0 : mem_q[rp_q];
   assign count = cnt_q;

endmodule // dcc_capture_fifo
`default_nettype wire

/* src/dcc_debug_capture.sv */
// Debug capture control: control bits, loop suppression, extended FIFO information
//
// Behaviour
// RULE_01: Extended info clears on POR and normal resets
// RULE_02: End-trace reset with enable, end-trigger keeps info
// RULE_03: Bit 7 shows paged access of word
// RULE_04: Flag zero: event data or unpaged address
// RULE_05: Flag one: page bits over address 13:0
// RULE_06: Bit 0 holds address bit 16
// RULE_07: Reserved control and info bits read zero
// RULE_08: Enable bit, held zero while secure
// RULE_09: Arm bit starts comparing and storing
// RULE_10: Break enable gates trace-end and C breaks
// RULE_11: Tag bit selects tag or force break
// RULE_12: Loop bit clear stores every change-of-flow
// RULE_13: Loop mode skips store on comparator match
// RULE_14: Loop mode stores mismatch, reloads comparator C
// RULE_15: Loop mode ignored in event-only modes
// RULE_16: Low byte read advances the FIFO
// RULE_17: Begin bit: trigger starts or ends storage
// RULE_18: Trigger register locked while armed
// RULE_19: Info register tracks word at read pointer
// RULE_20: Control fields readable and writable by software
`timescale 1ns/1ps
`default_nettype none
module dcc_debug_capture #(
   parameter int DEPTH = dcc_pkg::FIFO_DEPTH
) (
   input  wire logic        CLOCK,
   input  wire logic        RESET,
   input  wire logic [1:0]  RST_KIND,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output logic      [31:0] PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   input  wire logic        SECURE,
   input  wire logic        BUS_VALID,
   input  wire logic [15:0] CPU_ADDR,
   input  wire logic        PAGE_SEL,
   input  wire logic [2:0]  PPAGE,
   input  wire logic        COF_VALID,
   input  wire logic        EVENT_VALID,
   input  wire logic [7:0]  EVENT_DATA,
   input  wire logic        TRIGGER,
   output logic             BRK_FORCE,
   output logic             BRK_TAG
);

   import dcc_pkg::*;

   localparam int CW = $clog2(DEPTH + 1);

   logic [7:0]        ctrl_q;
   logic [7:0]        trig_q;
   logic [WORD_W-1:0] compc_q;
   dcc_trace_e        state_q;
   logic              brk_force_q;
   logic              brk_tag_q;

   logic              keep;
   logic              fifo_rst;
   logic              wr_stb;
   logic              rd_stb;
   logic              reg_hit;
   logic [31:0]       reg_rdata;

   logic              armed;
   logic              storing;
   logic              trace_end;
   logic              event_only;
   logic              loop_act;
   logic [ADDR_W-1:0] cpu_addr17;
   logic [WORD_W-1:0] cpu_word;
   logic [WORD_W-1:0] evt_word;
   logic              cand;
   logic [WORD_W-1:0] cand_word;
   logic              loop_hit;
   logic              push;
   logic              pop;
   logic              compc_hit;
   logic              brk_ev;
   logic              keep_trace;
   logic              keep_run;
   logic              ctrl_wr;
   logic              trig_wr;
   logic              compc_wr;
   logic              loop_load;
   logic              brk_busy;

   logic [WORD_W-1:0] head;
   logic              full;
   logic              empty;
   logic [CW-1:0]     count;
   logic [7:0]        fx_byte;

   // Reset cause handling
   // An end-trace reset that stopped on an end trigger must leave the trace readable
   assign keep_trace = (RST_KIND == RK_END_TRACE)
                    && ctrl_q[CTL_EN] && !trig_q[TRG_BEGIN]; // RULE_02
   assign keep_run   = (RST_KIND == RK_END_RUN);
   assign keep       = keep_trace || keep_run;
   assign fifo_rst   = RESET && !keep; // RULE_01

   // Register bus
   dcc_apb_slave u_apb (
      .clk       (CLOCK),
      .rst       (RESET),
      .psel      (PSEL),
      .penable   (PENABLE),
      .pwrite    (PWRITE),
      .reg_rdata (reg_rdata),
      .reg_hit   (reg_hit),
      .prdata    (PRDATA),
      .pready    (PREADY),
      .pslverr   (PSLVERR),
      .wr_stb    (wr_stb),
      .rd_stb    (rd_stb)
   );

   always_comb begin
      reg_hit = 1'b1;
      case (PADDR)
         OFS_FIFO_HIGH: reg_rdata = {24'h00_0000, head[15:8]};
         OFS_FIFO_LOW:  reg_rdata = {24'h00_0000, head[7:0]};
         OFS_FIFO_EXT:  reg_rdata = {24'h00_0000, fx_byte}; // RULE_19
         OFS_CTRL:      reg_rdata = {24'h00_0000, ctrl_q}; // RULE_20
         OFS_TRIG:      reg_rdata = {24'h00_0000, trig_q};
         OFS_COMPC:     reg_rdata = {14'h0000, compc_q};
         OFS_COUNT:     reg_rdata = {{(32 - CW){1'b0}}, count};
         default: begin
            reg_hit   = 1'b0;
            reg_rdata = 32'h0000_0000;
         end
      endcase
   end

   // Popping on the low byte lets software read extended and high bytes first
   assign pop = rd_stb && (PADDR == OFS_FIFO_LOW); // RULE_16

   // Trigger and comparator writes while armed are dropped without an error
   assign ctrl_wr  = wr_stb && (PADDR == OFS_CTRL);
   assign trig_wr  = wr_stb && (PADDR == OFS_TRIG) && !ctrl_q[CTL_ARM]; // RULE_18
   assign compc_wr = wr_stb && (PADDR == OFS_COMPC) && !ctrl_q[CTL_ARM];

   // Extended information byte of the word at the read pointer
   always_comb begin
      fx_byte           = 8'h00; // RULE_07
      fx_byte[FX_PAGED] = head[ADDR_W]; // RULE_03
      fx_byte[FX_MSB]   = head[ADDR_W-1]; // RULE_06
   end

   // Address forming
   always_comb begin
      if (PAGE_SEL) begin
         cpu_addr17 = {PPAGE, CPU_ADDR[13:0]}; // RULE_05
      end else begin
         cpu_addr17 = {1'b0, CPU_ADDR}; // RULE_04
      end
   end

   assign cpu_word = {PAGE_SEL, cpu_addr17};
   assign evt_word = {10'h000, EVENT_DATA}; // RULE_04

   // Capture path
   assign armed      = ctrl_q[CTL_EN] && ctrl_q[CTL_ARM]; // RULE_09
   assign storing    = armed && (state_q == TR_STORE);
   assign event_only = (trig_q[3:0] == MODE_EVT_B) || (trig_q[3:0] == MODE_A_EVT_B);
   assign loop_act   = ctrl_q[CTL_LOOP] && !event_only; // RULE_15
   assign cand       = event_only ? EVENT_VALID : COF_VALID; // RULE_12
   assign cand_word  = event_only ? evt_word : cpu_word;
   assign loop_hit   = loop_act && (cpu_addr17 == compc_q[ADDR_W-1:0]); // RULE_13
   assign push       = storing && cand && !loop_hit; // RULE_13
   assign loop_load  = push && loop_act; // RULE_14

   // With an end trigger the FIFO keeps the newest words, so full overwrites the oldest
   dcc_capture_fifo #(
      .W     (WORD_W),
      .DEPTH (DEPTH),
      .CW    (CW)
   ) u_fifo (
      .clk       (CLOCK),
      .rst       (fifo_rst),
      .push      (push),
      .pop       (pop),
      .overwrite (!trig_q[TRG_BEGIN]),
      .wdata     (cand_word),
      .head      (head),
      .full      (full),
      .empty     (empty),
      .count     (count)
   );

   // Trace sequencing
   always_comb begin
      trace_end = 1'b0;
      if (armed && state_q == TR_STORE) begin
         if (trig_q[TRG_BEGIN]) begin
            trace_end = full && !empty; // RULE_17
         end else begin
            trace_end = TRIGGER; // RULE_17
         end
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         state_q <= TR_IDLE;
      end else if (!armed) begin
         state_q <= TR_IDLE;
      end else begin
         case (state_q)
            TR_IDLE: begin
               state_q <= trig_q[TRG_BEGIN] ? TR_WAIT : TR_STORE; // RULE_17
            end
            TR_WAIT: begin
               if (TRIGGER) begin
                  state_q <= TR_STORE; // RULE_17
               end
            end
            TR_STORE: begin
               if (trace_end) begin
                  state_q <= TR_IDLE;
               end
            end
            default: begin
               state_q <= TR_IDLE;
            end
         endcase
      end
   end

   // Control register
   // A software write of arm in the same cycle as trace end wins, so a re-arm is not lost
   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         if (keep) begin
            ctrl_q         <= ctrl_q & ~CTL_KEEPCLR; // RULE_02
            ctrl_q[CTL_EN] <= ctrl_q[CTL_EN] && !SECURE; // RULE_08
         end else begin
            ctrl_q <= CTL_RST;
         end
      end else begin
         if (trace_end) begin
            ctrl_q[CTL_ARM] <= 1'b0;
         end
         if (ctrl_wr) begin
            ctrl_q <= PWDATA[7:0] & CTL_WMASK; // RULE_07
         end
         if (SECURE) begin
            ctrl_q[CTL_EN] <= 1'b0; // RULE_08
         end else if (ctrl_wr) begin
            ctrl_q[CTL_EN] <= PWDATA[CTL_EN]; // RULE_20
         end
      end
   end

   // Trigger register
   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         if (!keep) begin
            trig_q <= TRG_RST;
         end
      end else if (trig_wr) begin
         trig_q <= PWDATA[7:0] & TRG_WMASK; // RULE_18
      end
   end

   // Comparator C value; loop mode reloads it with each stored change-of-flow address
   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         if (!keep) begin
            compc_q <= COMPC_RST;
         end
      end else if (loop_load) begin
         compc_q <= cpu_word; // RULE_14
      end else if (compc_wr) begin
         compc_q <= PWDATA[WORD_W-1:0];
      end
   end

   // Break requests
   assign compc_hit = armed && BUS_VALID && (cpu_addr17 == compc_q[ADDR_W-1:0]);
   // A match held over back-to-back bus cycles must not stretch the request; an event
   // in the cycle right after a request is dropped, as the core is already breaking
   assign brk_busy  = brk_force_q || brk_tag_q;
   assign brk_ev    = ctrl_q[CTL_BRK] && (trace_end || compc_hit) && !brk_busy; // RULE_10

   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         brk_force_q <= 1'b0;
         brk_tag_q   <= 1'b0;
      end else begin
         brk_force_q <= brk_ev && !ctrl_q[CTL_TAG]; // RULE_11
         brk_tag_q   <= brk_ev && ctrl_q[CTL_TAG]; // RULE_11
      end
   end

   assign BRK_FORCE = brk_force_q;
   assign BRK_TAG   = brk_tag_q;

endmodule // dcc_debug_capture
`default_nettype wire

/* bench/dcc_debug_capture_assertions.sv */
// Port-level checker for the debug capture control
`timescale 1ns/1ps
`default_nettype none
module dcc_chk
   import dcc_pkg::*;
#(
   parameter int DEPTH = 8
) (
   input wire logic        CLOCK,
   input wire logic        RESET,
   input wire logic        PSEL,
   input wire logic        PENABLE,
   input wire logic        PWRITE,
   input wire logic [7:0]  PADDR,
   input wire logic [31:0] PRDATA,
   input wire logic        PREADY,
   input wire logic        PSLVERR,
   input wire logic        SECURE,
   input wire logic        BRK_FORCE,
   input wire logic        BRK_TAG
);
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (RESET);
   wire logic rd_acc = PSEL && PENABLE && !PWRITE;

   property p_ready;
      PSEL && PENABLE |-> PREADY;
   endproperty
   a_ready: assert property (p_ready) else $error("access phase without ready");
   property p_err_phase;
      PSLVERR |-> PSEL && PENABLE;
   endproperty
   a_err_phase: assert property (p_err_phase) else $error("error outside access phase");
   property p_unmap;
      rd_acc && (PADDR > OFS_COUNT || PADDR[1:0] != 2'h0) |-> PSLVERR && PRDATA == 32'h0000_0000;
   endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read not refused");
   property p_ctl_rsv;
      rd_acc && PADDR == OFS_CTRL |-> PRDATA[3:1] == 3'h0 && PRDATA[31:8] == 24'h00_0000;
   endproperty
   a_ctl_rsv: assert property (p_ctl_rsv) else $error("control reserved bits set");
   property p_fx_rsv;
      rd_acc && PADDR == OFS_FIFO_EXT |-> PRDATA[6:1] == 6'h00 && PRDATA[31:8] == 24'h00_0000;
   endproperty
   a_fx_rsv: assert property (p_fx_rsv) else $error("info reserved bits set");
   // Two cycles of secure first, so a set bit has had time to be forced off
   property p_secure;
      rd_acc && PADDR == OFS_CTRL && SECURE && $past(SECURE) && $past(SECURE, 2) |-> !PRDATA[CTL_EN];
   endproperty
   a_secure: assert property (p_secure) else $error("enable reads set while secure");
   property p_brk_excl;
      !(BRK_FORCE && BRK_TAG);
   endproperty
   a_brk_excl: assert property (p_brk_excl) else $error("force and tag together");
   property p_force_pulse;
      BRK_FORCE |=> !BRK_FORCE;
   endproperty
   a_force_pulse: assert property (p_force_pulse) else $error("force wider than 1");
   property p_tag_pulse;
      BRK_TAG |=> !BRK_TAG;
   endproperty
   a_tag_pulse: assert property (p_tag_pulse) else $error("tag wider than 1");
endmodule // dcc_chk

bind dcc_debug_capture dcc_chk #(.DEPTH(DEPTH)) i_dcc_chk (.CLOCK(CLOCK), .RESET(RESET),
   .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA),
   .PREADY(PREADY), .PSLVERR(PSLVERR), .SECURE(SECURE), .BRK_FORCE(BRK_FORCE),
   .BRK_TAG(BRK_TAG));
`default_nettype wire

/* bench/dcc_cpu_model.sv */
// CPU-side model: change-of-flow, event and trigger pulses
`timescale 1ns/1ps
`default_nettype none
module dcc_cpu_model (
   input  wire logic  clk,
   output logic       bus_valid,
   output logic [15:0] cpu_addr,
   output logic       page_sel,
   output logic [2:0] ppage,
   output logic       cof_valid,
   output logic       event_valid,
   output logic [7:0] event_data,
   output logic       trigger
);
   initial begin
      {bus_valid, cof_valid, event_valid, trigger, page_sel} = 5'h00;
      {cpu_addr, ppage, event_data} = 27'h000_0000;
   end
   // Idle lines show the inverse of the last value, never a stale copy
   task automatic change_of_flow(input logic [15:0] a, input logic p, input logic [2:0] g);
      @(posedge clk);
      {bus_valid, cof_valid, page_sel, ppage, cpu_addr} <= {2'h3, p, g, a};
      @(posedge clk);
      {bus_valid, cof_valid, page_sel, ppage, cpu_addr} <= {2'h0, ~p, ~g, ~a};
   endtask
   task automatic evt(input logic [7:0] d);
      @(posedge clk);
      {event_valid, event_data} <= {1'b1, d};
      @(posedge clk);
      {event_valid, event_data} <= {1'b0, ~d};
   endtask
   task automatic trig;
      @(posedge clk);
      trigger <= 1'b1;
      @(posedge clk);
      trigger <= 1'b0;
   endtask
endmodule // dcc_cpu_model
`default_nettype wire

/* bench/tb_top.sv */
// Self-checking bench for the debug capture control
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import dcc_pkg::*;
   logic        clock = 1'b0;
   logic        reset = 1'b1;
   logic [1:0]  rst_kind = RK_POR;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic        secure = 1'b0;
   wire logic [31:0] prdata;
   wire logic [15:0] cpu_addr;
   wire logic [7:0]  event_data;
   wire logic [2:0]  ppage;
   wire logic pready, pslverr, bus_valid, page_sel, cof_valid, event_valid, trigger;
   wire logic brk_force, brk_tag;
   int n_mismatch = 0;
   int checks_done = 0;
   int n_force = 0;
   int n_tag = 0;
   int cyc = 0;

   always #5 clock = ~clock;

   dcc_debug_capture #(.DEPTH(8)) i_dcc_debug_capture (.CLOCK(clock), .RESET(reset),
      .RST_KIND(rst_kind), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
      .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .SECURE(secure), .BUS_VALID(bus_valid), .CPU_ADDR(cpu_addr), .PAGE_SEL(page_sel),
      .PPAGE(ppage), .COF_VALID(cof_valid), .EVENT_VALID(event_valid),
      .EVENT_DATA(event_data), .TRIGGER(trigger), .BRK_FORCE(brk_force), .BRK_TAG(brk_tag));
   dcc_cpu_model i_dcc_cpu_model (.clk(clock), .bus_valid(bus_valid), .cpu_addr(cpu_addr),
      .page_sel(page_sel), .ppage(ppage), .cof_valid(cof_valid),
      .event_valid(event_valid), .event_data(event_data), .trigger(trigger));

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   always @(posedge clock) begin
      cyc++;
      if (brk_force === 1'b1) n_force++;
      if (brk_tag === 1'b1) n_tag++;
      if (cyc == 3000) begin
         n_mismatch++;
         report_and_stop;
      end
   end

   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      checks_done++;
      if (s !== e) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
      @(posedge clock);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock);
      while (pready !== 1'b1) @(posedge clock);
      r = prdata;
      {psel, penable} <= 2'h0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] r;
      apb(1'b1, a, {24'h00_0000, d}, r);
   endtask
   task automatic rc(input logic [7:0] a, input logic [7:0] e, input string nm);
      logic [31:0] r;
      apb(1'b0, a, 32'h0000_0000, r);
      chk(nm, r, {24'h00_0000, e});
   endtask
   task automatic rst(input logic [1:0] k);
      @(posedge clock);
      {reset, rst_kind} <= {1'b1, k};
      repeat (2) @(posedge clock);
      reset <= 1'b0;
   endtask

   initial begin
      logic [31:0] r;
      repeat (10) @(posedge clock);
      reset <= 1'b0;
      rc(OFS_CTRL, 8'h00, "ctrl reset");
      rc(OFS_FIFO_EXT, 8'h00, "ext reset");
      rc(8'h1C, 8'h00, "unmapped");
      wr(OFS_CTRL, 8'hFF);
      rc(OFS_CTRL, 8'hF1, "ctrl rw");
      wr(OFS_CTRL, 8'h00);
      secure <= 1'b1;
      wr(OFS_CTRL, 8'h80);
      rc(OFS_CTRL, 8'h00, "ctrl secure");
      secure <= 1'b0;
      $display("register test done");
      wr(OFS_CTRL, 8'hD0);
      i_dcc_cpu_model.change_of_flow(16'h1234, 1'b0, 3'h0);
      i_dcc_cpu_model.change_of_flow(16'h1234, 1'b0, 3'h0);
      i_dcc_cpu_model.change_of_flow(16'hA5A5, 1'b1, 3'h5);
      i_dcc_cpu_model.trig;
      i_dcc_cpu_model.change_of_flow(16'h7777, 1'b0, 3'h0);
      rc(OFS_CTRL, 8'h90, "ctrl after end");
      rc(OFS_COUNT, 8'h03, "count");
      rc(OFS_FIFO_EXT, 8'h00, "ext unpaged");
      rc(OFS_FIFO_HIGH, 8'h12, "high");
      rc(OFS_FIFO_LOW, 8'h34, "low");
      rc(OFS_FIFO_LOW, 8'h34, "low dup");
      rc(OFS_FIFO_EXT, 8'h81, "ext paged");
      rc(OFS_FIFO_HIGH, 8'h65, "high paged");
      chk("force breaks", n_force, 1);
      chk("tag breaks", n_tag, 0);
      rst(RK_END_TRACE);
      rc(OFS_FIFO_EXT, 8'h81, "ext kept");
      rc(OFS_CTRL, 8'h80, "ctrl kept");
      rst(RK_OTHER);
      rc(OFS_FIFO_EXT, 8'h00, "ext cleared");
      $display("capture and reset test done");
      wr(OFS_CTRL, 8'hC1);
      wr(OFS_TRIG, 8'h07);
      rc(OFS_TRIG, 8'h00, "trig locked");
      i_dcc_cpu_model.change_of_flow(16'h0111, 1'b0, 3'h0);
      i_dcc_cpu_model.change_of_flow(16'h0111, 1'b0, 3'h0);
      i_dcc_cpu_model.change_of_flow(16'h0222, 1'b0, 3'h0);
      i_dcc_cpu_model.trig;
      rc(OFS_COUNT, 8'h02, "loop count");
      apb(1'b0, OFS_COMPC, 32'h0000_0000, r);
      chk("compc", r, 32'h0000_0222);
      rc(OFS_FIFO_LOW, 8'h11, "loop low");
      rc(OFS_FIFO_LOW, 8'h22, "loop low");
      chk("no break", n_force, 1);
      wr(OFS_CTRL, 8'hF0);
      i_dcc_cpu_model.trig;
      rc(OFS_CTRL, 8'hB0, "ctrl tag");
      chk("tag breaks", n_tag, 1);
      $display("loop and break test done");
      wr(OFS_TRIG, {4'h0, MODE_EVT_B});
      wr(OFS_CTRL, 8'hC1);
      // Idle address lines now equal comparator C, so loop mode would drop the events
      i_dcc_cpu_model.change_of_flow(16'hFDDD, 1'b1, 3'h0);
      i_dcc_cpu_model.evt(8'h5A);
      i_dcc_cpu_model.evt(8'h5A);
      i_dcc_cpu_model.trig;
      rc(OFS_COUNT, 8'h02, "event count");
      rc(OFS_FIFO_LOW, 8'h5A, "event low");
      wr(OFS_TRIG, {4'h0, MODE_A_EVT_B});
      wr(OFS_CTRL, 8'hC1);
      i_dcc_cpu_model.evt(8'hC3);
      i_dcc_cpu_model.trig;
      rc(OFS_COUNT, 8'h02, "mode 4 count");
      $display("event test done");
      rst(RK_POR);
      wr(OFS_TRIG, 8'h40);
      wr(OFS_CTRL, 8'hD0);
      i_dcc_cpu_model.change_of_flow(16'h0333, 1'b0, 3'h0);
      i_dcc_cpu_model.trig;
      repeat (8) i_dcc_cpu_model.change_of_flow(16'h0444, 1'b0, 3'h0);
      rc(OFS_CTRL, 8'h90, "ctrl full end");
      rc(OFS_COUNT, 8'h08, "count full");
      rc(OFS_FIFO_LOW, 8'h44, "low begin");
      chk("full break", n_force, 2);
      $display("begin trigger test done");
      report_and_stop;
   end
endmodule // tb_top
`default_nettype wire
